// ==== include/sbs_map.svh ====
`ifndef SBS_MAP_SVH
`define SBS_MAP_SVH

// ****************************************************************************
// organisation and timing constants
// ****************************************************************************
`define SBS_ADDR_W        19
`define SBS_LANES         4
`define SBS_PARITY        1
`define SBS_BURST_W       2
`define SBS_BURST_LEN     4
`define SBS_SYNC_STAGES   3
`define SBS_FLOAT_NS      3
`define SBS_CLK_MHZ       200
`define SBS_FLOAT_CYC     ((`SBS_FLOAT_NS * `SBS_CLK_MHZ) / 1000 < 1 ? 1 : \
                           (`SBS_FLOAT_NS * `SBS_CLK_MHZ) / 1000)
`define SBS_ORDER_LINEAR  1'b0
`define SBS_RDPIPE_RST    1'b0

`endif

// ==== include/sbs_pkg.sv ====
package sbs_pkg;

  // ****************************************************************************
  // control sampled at a clock edge
  // ****************************************************************************
  typedef struct packed {
    logic chip_en_n;
    logic expansion_select_hi;
    logic expansion_select_lo_n;
    logic proc_addr_strobe_n;
    logic ctrl_addr_strobe_n;
    logic burst_advance_n;
    logic lane_write_gate_n;
    logic all_lanes_write_n;
  } sbs_ctrl_t;

  typedef enum logic [2:0] {
    SBS_IDLE  = 3'b001,
    SBS_READ  = 3'b010,
    SBS_WRITE = 3'b100
  } sbs_state_t;

endpackage

// ==== rtl/sbs_burst_cnt.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "sbs_map.svh"

module sbs_burst_cnt #(
  parameter int ADDR_W = `SBS_ADDR_W
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              load,
  input  wire logic [ADDR_W-1:0] load_addr,
  input  wire logic              advance,
  input  wire logic              order_lin,
  output logic      [ADDR_W-1:0] word_addr
);

  logic [ADDR_W-1:0] base_q;
  logic [1:0]        cnt_q;
  logic [1:0]        cnt_nx;
  logic [1:0]        low;

  // ****************************************************************************
  // two-bit burst counter
  // ****************************************************************************
  // load clears the count, advance steps it and wraps after four
  always_ff @(posedge clk) begin
    if (!rstn) begin
      base_q <= '0;
      cnt_q  <= 2'h0;
    end else if (load) begin
      base_q <= load_addr;
      cnt_q  <= 2'h0;
    end else if (advance) begin
      cnt_q  <= cnt_nx;
    end
  end

  // the advance cycle already addresses the next word, so no word is fetched twice
  // interleave xors, linear adds modulo four; upper bits untouched
  always_comb begin
    cnt_nx = advance ? cnt_q + 2'h1 : cnt_q;
    if (order_lin)
      low = base_q[1:0] + cnt_nx;
    else
      low = base_q[1:0] ^ cnt_nx;
    word_addr = {base_q[ADDR_W-1:2], low};
  end

endmodule

`default_nettype wire

// ==== rtl/sbs_core.sv ====
// Behaviour
// - every synchronous input is captured on the rising clock edge only
// - address, data, three enables, burst, lane and global write controls are registered
// - a two-bit counter supplies follow-on word addresses in a burst
// - the order select chooses interleaved or linear sequence
// - output enable is sampled by the output flops; snooze passes a three-stage synchroniser
// - a write updates one to all byte lanes per the write controls
// - either address strobe starts a burst and loads a new address
// - counter steps only while burst advance is low
// - address and write controls are held so the array write self-times
// - on two-lane builds lane enables a and b gate byte plus parity
// - each lane enable gates only its own byte and parity bit
// - global write low writes every lane regardless of lane enables
// - parity lanes exist only when the parity option is set
// - deselect right after a read floats the bus two edges after the edge that samples it
// - selection needs primary low, expansion high and expansion low enables
// - snooze high puts the device into low-power standby
// - order select low means linear, high means interleaved, held static
// - processor strobe ignored when primary enable high; starts a read
// - burst advance high holds the address, inserting wait states
// - lane enables count only while the lane gate is low
`timescale 1ns/10ps
`default_nettype none
`include "sbs_map.svh"

module sbs_core #(
  parameter int ADDR_W = `SBS_ADDR_W,
  parameter int LANES  = `SBS_LANES,
  parameter bit PARITY = `SBS_PARITY,
  parameter int LANE_W = 8 + int'(PARITY)
) (
  input  wire logic                    clk,
  input  wire logic                    rstn,
  input  wire logic [ADDR_W-1:0]       addr,
  input  wire sbs_pkg::sbs_ctrl_t      ctrl,
  input  wire logic [LANES-1:0]        lane_write_n,
  input  wire logic                    burst_order_sel_n,
  input  wire logic                    out_enable_n,
  input  wire logic                    snooze_in,
  input  wire logic [LANES*LANE_W-1:0] data_in,
  output logic      [LANES*LANE_W-1:0] data_out,
  output logic      [LANES*LANE_W-1:0] data_oe,
  output logic                         standby
);

  localparam int DEPTH = 1 << ADDR_W;
  localparam int W     = LANES * LANE_W;

  // ****************************************************************************
  // input registers
  // ****************************************************************************
  logic [ADDR_W-1:0]   addr_q;
  sbs_pkg::sbs_ctrl_t  ctrl_q;
  logic [LANES-1:0]    lane_wr_n_q;
  logic [W-1:0]        din_q;

  // all synchronous pins sampled on the rising edge only
  always_ff @(posedge clk) begin
    if (!rstn) begin
      addr_q      <= '0;
      ctrl_q      <= '1;
      lane_wr_n_q <= '1;
      din_q       <= '0;
    end else begin
      addr_q      <= addr;
      ctrl_q      <= ctrl;
      lane_wr_n_q <= lane_write_n;
      din_q       <= data_in;
    end
  end

  // ****************************************************************************
  // static and asynchronous level synchronisers
  // ****************************************************************************
  logic [2:0] order_sync_q;
  logic [2:0] snooze_sync_q;
  logic       order_lin_q;
  logic       snooze_q;

  // order select and snooze come from outside; three stages, 2nd/3rd must agree
  always_ff @(posedge clk) begin
    if (!rstn) begin
      order_sync_q  <= 3'h0;
      snooze_sync_q <= 3'h0;
    end else begin
      order_sync_q  <= {order_sync_q[1:0], burst_order_sel_n};
      snooze_sync_q <= {snooze_sync_q[1:0], snooze_in};
    end
  end

  // filtered levels; order select low means linear
  always_ff @(posedge clk) begin
    if (!rstn) begin
      order_lin_q <= 1'b1;
      snooze_q    <= 1'b0;
    end else begin
      if (order_sync_q[2] == order_sync_q[1])
        order_lin_q <= (order_sync_q[2] == `SBS_ORDER_LINEAR);
      if (snooze_sync_q[2] == snooze_sync_q[1])
        snooze_q <= snooze_sync_q[2];
    end
  end

  // ****************************************************************************
  // cycle decode
  // ****************************************************************************
  logic selected;
  logic proc_start;
  logic ctrl_start;
  logic start;
  logic any_write;
  logic [LANES-1:0] lane_en;

  always_comb begin
    // three enables together select the device
    selected   = !ctrl_q.chip_en_n && ctrl_q.expansion_select_hi &&
                 !ctrl_q.expansion_select_lo_n;
    // processor strobe honoured only while primary enable is low
    proc_start = !ctrl_q.proc_addr_strobe_n && !ctrl_q.chip_en_n;
    ctrl_start = !ctrl_q.ctrl_addr_strobe_n;
    start      = proc_start || ctrl_start;
    // lane enables only count when the lane gate is low
    lane_en    = ctrl_q.lane_write_gate_n ? '0 : ~lane_wr_n_q;
    if (!ctrl_q.all_lanes_write_n)
      lane_en = '1;
    // processor strobe start is always a read
    any_write  = (lane_en != '0) && !proc_start;
  end

  // ****************************************************************************
  // burst address
  // ****************************************************************************
  logic [ADDR_W-1:0] word_addr;
  logic [ADDR_W-1:0] wr_addr_q;
  logic              advance;

  // burst advance high holds the address as a wait state
  assign advance = !ctrl_q.burst_advance_n && !start;

  sbs_burst_cnt #(
    .ADDR_W (ADDR_W)
  ) u_cnt (
    .clk       (clk),
    .rstn      (rstn),
    .load      (start && selected),
    .load_addr (addr_q),
    .advance   (advance),
    .order_lin (order_lin_q),
    .word_addr (word_addr)
  );

  // ****************************************************************************
  // burst state
  // ****************************************************************************
  sbs_pkg::sbs_state_t st_q;
  logic                in_burst;

  assign in_burst = (st_q != sbs_pkg::SBS_IDLE);

  // track whether a selected burst is in progress
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_q <= sbs_pkg::SBS_IDLE;
    end else begin
      case (st_q)
        sbs_pkg::SBS_IDLE: begin
          if (start && selected)
            st_q <= any_write ? sbs_pkg::SBS_WRITE : sbs_pkg::SBS_READ;
        end
        sbs_pkg::SBS_READ, sbs_pkg::SBS_WRITE: begin
          if (start && !selected)
            st_q <= sbs_pkg::SBS_IDLE;
          else if (start)
            st_q <= any_write ? sbs_pkg::SBS_WRITE : sbs_pkg::SBS_READ;
          else if (any_write)
            st_q <= sbs_pkg::SBS_WRITE;
          else
            st_q <= sbs_pkg::SBS_READ;
        end
        default: st_q <= sbs_pkg::SBS_IDLE;
      endcase
    end
  end

  // ****************************************************************************
  // memory array with self-timed write
  // ****************************************************************************
  logic [ADDR_W-1:0] acc_addr;
  logic [W-1:0]      wr_data_q;
  logic [LANES-1:0]  wr_lane_q;
  logic              wr_pend_q;
  logic              rd_ok;
  logic              wr_ok;

  // a write only needs the controls for one edge; they are held internally
  assign wr_ok = any_write && !snooze_q && (in_burst ? !start || selected : start && selected);
  assign rd_ok = !any_write && !snooze_q &&
                 (start ? selected : (st_q != sbs_pkg::SBS_IDLE));

  // a strobe uses the freshly loaded address, any other cycle the burst counter
  assign acc_addr = start ? addr_q : word_addr;

  // capture address, data and lane mask for the array write
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_pend_q <= 1'b0;
      wr_lane_q <= '0;
      wr_data_q <= '0;
      wr_addr_q <= '0;
    end else begin
      wr_pend_q <= wr_ok;
      wr_lane_q <= lane_en;
      wr_data_q <= din_q;
      wr_addr_q <= acc_addr;
    end
  end

  // read word assembled from the per-lane fetch flops
  wire logic [W-1:0] rd_word;

  // one array per lane, so each lane enable writes only its own byte and parity bit
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [LANE_W-1:0] mem_q [DEPTH];
    logic [LANE_W-1:0] rd_q;
    logic              wr_here;

    assign wr_here = wr_pend_q && wr_lane_q[g];

    // self-timed write of the held lane data
    always_ff @(posedge clk) begin
      if (wr_here)
        mem_q[wr_addr_q] <= wr_data_q[g*LANE_W +: LANE_W];
    end

    // fetch the burst word; a write landing on the same word at this edge is forwarded
    always_ff @(posedge clk) begin
      if (!rstn)
        rd_q <= '0;
      else if (rd_ok)
        rd_q <= (wr_here && (wr_addr_q == acc_addr)) ? wr_data_q[g*LANE_W +: LANE_W] :
                                                       mem_q[acc_addr];
    end

    assign rd_word[g*LANE_W +: LANE_W] = rd_q;
  end

  // ****************************************************************************
  // read path and output drivers
  // ****************************************************************************
  logic rd_valid_q;

  // remember whether this edge fetched a word for the bus
  always_ff @(posedge clk) begin
    if (!rstn)
      rd_valid_q <= `SBS_RDPIPE_RST;
    else
      rd_valid_q <= rd_ok;
  end

  // drive data from flops; float after a deselected cycle or in snooze
  always_ff @(posedge clk) begin
    if (!rstn) begin
      data_out <= '0;
      data_oe  <= '0;
      standby  <= 1'b0;
    end else begin
      data_out <= rd_word;
      data_oe  <= {W{rd_valid_q && !out_enable_n && !snooze_q}};
      standby  <= snooze_q;
    end
  end

endmodule

`default_nettype wire

// ==== verification/sbs_core_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************************
// port checker for the burst memory core
// ****************************************************************************
module sbs_core_asserts #(
  parameter int LANES  = 4,
  parameter int LANE_W = 9
) (
  input wire logic                    clk,
  input wire logic                    rstn,
  input wire sbs_pkg::sbs_ctrl_t      ctrl,
  input wire logic                    out_enable_n,
  input wire logic                    snooze_in,
  input wire logic [LANES*LANE_W-1:0] data_oe,
  input wire logic                    standby
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic rd_cmd;
  // selected read started by the controller strobe
  assign rd_cmd = !ctrl.ctrl_addr_strobe_n && !ctrl.chip_en_n && ctrl.expansion_select_hi
                  && !ctrl.expansion_select_lo_n && ctrl.lane_write_gate_n
                  && ctrl.all_lanes_write_n && !snooze_in && !standby;
  property p_oe_off; out_enable_n |=> data_oe == '0; endproperty
  a_oe_off: assert property (p_oe_off) else $error("bus driven while disabled");
  property p_oe_word; data_oe == '0 || data_oe == '1; endproperty
  a_oe_word: assert property (p_oe_word) else $error("drive bits disagree");
  property p_read; rd_cmd ##1 !out_enable_n [*2] |=> data_oe == '1; endproperty
  a_read: assert property (p_read) else $error("read data not driven");
  property p_desel; !ctrl.ctrl_addr_strobe_n && ctrl.chip_en_n |-> ##3 data_oe == '0;
  endproperty
  a_desel: assert property (p_desel) else $error("bus not floated");
  property p_expand;
    !ctrl.ctrl_addr_strobe_n && (!ctrl.expansion_select_hi || ctrl.expansion_select_lo_n)
      |-> ##3 data_oe == '0;
  endproperty
  a_expand: assert property (p_expand) else $error("driven while unselected");
  property p_snz_on; snooze_in [*6] |-> standby; endproperty
  a_snz_on: assert property (p_snz_on) else $error("standby not entered");
  property p_snz_off; !snooze_in [*6] |-> !standby; endproperty
  a_snz_off: assert property (p_snz_off) else $error("standby not left");
  property p_reset; disable iff (1'b0) !rstn |=> data_oe == '0 && !standby; endproperty
  a_reset: assert property (p_reset) else $error("outputs active in reset");
  c_read: cover property (rd_cmd ##3 data_oe == '1);
  c_desel: cover property (!ctrl.ctrl_addr_strobe_n && ctrl.chip_en_n);
  c_snooze: cover property ($rose(standby));
endmodule
bind sbs_core sbs_core_asserts #(
  .LANES (LANES),
  .LANE_W(LANE_W)
) sbs_core_asserts_inst (
  .clk         (clk),
  .rstn        (rstn),
  .ctrl        (ctrl),
  .out_enable_n(out_enable_n),
  .snooze_in   (snooze_in),
  .data_oe     (data_oe),
  .standby     (standby)
);
`default_nettype wire

// ==== verification/sbs_host.sv ====
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************************
// controller model on the synchronous bus
// ****************************************************************************
module sbs_host (
  input  wire logic               clk,
  output var logic [18:0]         addr,
  output var sbs_pkg::sbs_ctrl_t  ctrl,
  output var logic [3:0]          lane_write_n,
  output var logic [35:0]         data_in
);
  // one bus cycle launched at the falling edge and held a full period
  task automatic drive(input logic [18:0] a, input logic [7:0] c, input logic [3:0] l,
                       input logic [35:0] d);
    @(negedge clk);
    addr         <= a;
    ctrl         <= c;
    lane_write_n <= l;
    data_in      <= d;
  endtask
  // bus idle and deselected from time zero
  initial begin
    addr         = 19'h0_0000;
    ctrl         = 8'hDF;
    lane_write_n = 4'hF;
    data_in      = 36'h0_0000_0000;
  end
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************************
// self-checking bench for the burst memory core
// ****************************************************************************
module testbench;
  logic               clk = 1'b0;
  logic               rstn = 1'b0;
  logic               order_n = 1'b0;
  logic               oe_n = 1'b0;
  logic               snz = 1'b0;
  logic [18:0]        addr;
  sbs_pkg::sbs_ctrl_t ctrl;
  logic [3:0]         lanes;
  logic [35:0]        din;
  logic [35:0]        dout;
  logic [35:0]        doe;
  logic               stby;
  int                 num_errors = 0;
  int                 n_tests = 0;
  int                 cyc = 0;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  sbs_host sbs_host_inst (.clk(clk), .addr(addr), .ctrl(ctrl), .lane_write_n(lanes),
                          .data_in(din));
  sbs_core sbs_core_inst (.clk(clk), .rstn(rstn), .addr(addr), .ctrl(ctrl),
    .lane_write_n(lanes), .burst_order_sel_n(order_n), .out_enable_n(oe_n),
    .snooze_in(snz), .data_in(din), .data_out(dout), .data_oe(doe), .standby(stby));
  function automatic logic [35:0] pat(input logic [18:0] a);
    return {a[17:0], ~a[17:0]};
  endfunction
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) sbs_host_inst.drive(19'h0_0000, 8'hDF, 4'hF, ~din);
  endtask
  // burst read of n words from a, then tail; each word checked as it leaves
  task automatic rd(input logic [18:0] a, input logic [7:0] go, input int n,
                    input logic [7:0] tail, input logic [35:0] ov);
    logic [18:0] w;
    for (int i = 0; i <= n + 3; i++) begin
      sbs_host_inst.drive(a, i == 0 ? go : (i < n ? 8'h5B : tail), 4'hF, ~din);
      w = {a[18:2], order_n ? (a[1:0] ^ 2'(i - 3)) : (a[1:0] + 2'(i - 3))};
      if (i >= 3 && i < n + 3) chk(dout, pat(w) | ov);
      if (i >= 3 && i < n + 3) chk(doe, '1);
      if (i == n + 3 && tail != 8'hDF) chk(doe, '0);
    end
  endtask
  task automatic t_write_all;
    for (int k = 0; k < 4; k++)
      sbs_host_inst.drive(19'h0_1234 + 19'(k), 8'h56, 4'hF, pat(19'h0_1234 + 19'(k)));
    idle(2);
    rd(19'h0_1234, 8'h57, 1, 8'hDF, '0);
  endtask
  task automatic t_burst(input logic o, input logic [18:0] a, input logic [7:0] go);
    order_n <= o;
    idle(6);
    rd(a, go, 4, 8'hDF, '0);
  endtask
  task automatic t_lane;
    sbs_host_inst.drive(19'h0_1234, 8'h55, 4'b1101, '1);
    sbs_host_inst.drive(19'h0_1234, 8'h57, 4'h0, '0);
    idle(2);
    rd(19'h0_1234, 8'h57, 1, 8'hDF, 36'h0_0003_FE00);
  endtask
  task automatic t_desel;
    rd(19'h0_1235, 8'h57, 1, 8'hD7, '0);
    rd(19'h0_1235, 8'h57, 1, 8'h17, '0);
    rd(19'h0_1235, 8'h57, 1, 8'h77, '0);
  endtask
  task automatic t_ignore;
    sbs_host_inst.drive(19'h0_1235, 8'h57, 4'hF, ~din);
    repeat (5) sbs_host_inst.drive(19'h0_1236, 8'hCF, 4'hF, ~din);
    chk(doe, '1);
    chk(dout, pat(19'h0_1235));
  endtask
  task automatic t_oe;
    oe_n <= 1'b1;
    sbs_host_inst.drive(19'h0_1235, 8'h57, 4'hF, ~din);
    idle(4);
    chk(doe, '0);
    oe_n <= 1'b0;
    idle(1);
    chk(doe, '1);
  endtask
  task automatic t_snooze;
    snz <= 1'b1;
    idle(6);
    chk(36'(stby), 36'h1);
    snz <= 1'b0;
    idle(6);
    chk(36'(stby), 36'h0);
  endtask
  task automatic give_verdict;
    if (num_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      num_errors++;
      give_verdict();
    end
  end
  // main sequence
  initial begin
    repeat (5) @(negedge clk);
    rstn <= 1'b1;
    idle(3);
    t_write_all();
    t_burst(1'b0, 19'h0_1235, 8'h57);
    t_burst(1'b1, 19'h0_1236, 8'h4F);
    t_lane();
    t_desel();
    t_ignore();
    t_oe();
    t_snooze();
    give_verdict();
  end
endmodule
`default_nettype wire
